/* File: shared/sec_flash_map.svh */
`ifndef SEC_FLASH_MAP_SVH
`define SEC_FLASH_MAP_SVH
// opcodes
`define OP_RDSR       8'h05
`define OP_WREN       8'h06
`define OP_WRAP_READ  8'h0C
`define OP_QPI_ON     8'h38
`define OP_SEC_PROG   8'h42
`define OP_SEC_ERASE  8'h44
`define OP_SEC_READ   8'h48
`define OP_SFDP       8'h5A
`define OP_SET_WRAP   8'h77
`define OP_SET_PARAM  8'hC0
`define OP_QPI_OFF    8'hFF
// security area and read framing
`define SEC_BYTES     1024
`define SEC_AW        10
`define ERASED_BYTE   8'hFF
`define ADDR_LAST_IDX 2'd2
`define SPI_DUMMY     4'd8
// parameter table tail: 9Ah..A3h, 97h, rest reserved
`define PT_BASE       8'h9A
`define PT_LEN        8'd10
`define PT_TAIL       {8'h08,8'hEB,8'h0C,8'h20,8'h0F,8'h52,8'h10,8'hD8,8'h00,8'h00}
`define PT_NOQ_ADDR   8'h97
`define PT_NOQ_VAL    8'h00
`define PT_RSVD       8'hFF
// status byte and parameter fields
`define SR_WIP_BIT    0
`define SR_WEL_BIT    1
`define P_DUMMY_MSB   5
`define P_DUMMY_LSB   4
`define P_WRAP_MSB    1
`define P_WRAP_LSB    0
`define W_WRAP_MSB    5
`define W_WRAP_LSB    4
`define WRAP_MIN      7'd8
// self-timed cycles, in hclk cycles
`define ERASE_CYCLES  2048
`define PROG_CYCLES   64
// host controller registers (AHB byte addresses)
`define REG_CTRL      8'h00
`define REG_TX        8'h04
`define REG_RX        8'h08
`define REG_STAT      8'h0C
`define CTRL_CS_BIT   0
`define CTRL_QUAD_BIT 1
`define TX_RECV_BIT   8
`define STAT_BUSY_BIT 0
// link timing
`define HCLK_PERIOD_NS 50
`define LINK_PERIOD_NS 400
`endif

/* File: shared/sec_flash_pkg.sv */
package sec_flash_pkg;
   typedef enum logic [2:0] {
      ST_OPC, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_TAIL, ST_SKIP
   } dev_state_t;
endpackage

/* File: shared/sec_flash_if.sv */
`timescale 1ns/1ps
interface sec_flash_if;
   logic       cs_n;      // chip select, low active
   logic       sclk;      // link clock from host
   logic [3:0] host_out;  // host drive value
   logic [3:0] host_oe;   // host drive enable per lane
   logic [3:0] dev_out;   // device drive value
   logic [3:0] dev_oe;    // device drive enable per lane
   logic [3:0] io;        // resolved lane level, pulled high when idle
   // undriven lanes read high, as with a pull-up
   assign io = (dev_oe & dev_out) | (host_oe & ~dev_oe & host_out)
             | ~(dev_oe | host_oe);
   modport host (output cs_n, sclk, host_out, host_oe, input io);
   modport device (input cs_n, sclk, io, output dev_out, dev_oe);
endinterface

/* File: hw/sec_flash_dev.sv */
`timescale 1ns/1ps
`include "sec_flash_map.svh"
// Summary of operation
// - table reports three erase types, fourth zero
// - table reports quad fast read: 08h, EBh
// - one 1024-byte security area, separate array
// - erase needs write latch set first
// - erase address upper bits zero, low ignored
// - erase runs only if select rises byte-aligned
// - erase self-timed, busy flag held, status readable
// - write latch cleared after erase ends
// - lock flag blocks erase and program while set
// - program 1..256 bytes, needs write latch
// - program address: quarter bits, byte bits
// - read: opcode, address, 8 dummy, MSB out
// - read address wraps 3FFh to 00h
// - read refused while a cycle is busy
// - parameter set only in four-wire mode
// - parameter bits 5-4 pick dummy clocks
// - parameter bits 1-0 pick wrap length
// - reset defaults: 8-byte wrap, 2 dummies
// - SPI wrap set by 77h bits 5-4
// - wrap read loops inside aligned window
// - four-wire entry by 38h only if allowed
// - one mode at a time, entry keeps settings
// - FFh returns to SPI, keeps settings
module sec_flash_dev import sec_flash_pkg::*; #(
   parameter int ERASE_CYCLES = `ERASE_CYCLES, // self-timed erase length
   parameter int PROG_CYCLES  = `PROG_CYCLES   // self-timed program length
) (
   input  wire logic     hclk,                   // system clock
   input  wire logic     hresetn,                // async reset, low active
   sec_flash_if.device   link,                   // serial link pins
   input  wire logic     secure_lock_flag,       // area locked
   input  wire logic     quad_allow_flag,        // four-wire entry allowed
   output logic          four_wire_command_mode, // mode status
   output logic          write_latch_flag,       // write latch status
   output logic          op_in_progress_flag     // busy status
);
   logic        cs_s1, cs_s2, cs_d, ck_s1, ck_s2, ck_d;
   logic        rise, fall, cs_up, byte_done, op_ok, armed, erasing;
   logic [3:0]  io_s1, io_s2, dcnt;
   dev_state_t  st;
   logic [7:0]  op, sh, prm, osh, rd_byte, next_sh, pt_idx;
   logic [2:0]  bitcnt, ocnt, step, next_bitcnt;
   logic [1:0]  acnt, wrap_sel, dummy_sel;
   logic [23:0] addr;
   logic [15:0] busy_cnt;
   logic [7:0]  mem [`SEC_BYTES];
   logic [9:0]  wmask, next_rd_addr;
   logic [6:0]  wlen;
   logic [79:0] pt_tail;
   // pin synchronisers; data taken from the second stage, edges from the second and third
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {cs_s1, cs_s2, cs_d} <= 3'h7;
         {ck_s1, ck_s2, ck_d} <= 3'h0;
         {io_s1, io_s2}       <= 8'h00;
      end else begin
         {cs_s1, cs_s2, cs_d} <= {link.cs_n, cs_s1, cs_s2};
         {ck_s1, ck_s2, ck_d} <= {link.sclk, ck_s1, ck_s2};
         {io_s1, io_s2}       <= {link.io, io_s1};
      end
   end
   // link edges seen through the synchronisers, only inside a frame
   assign rise  = ck_s2 & ~ck_d & ~cs_s2;
   assign fall  = ~ck_s2 & ck_d & ~cs_s2;
   assign cs_up = cs_s2 & ~cs_d;
   assign step  = four_wire_command_mode ? 3'd4 : 3'd1;
   assign next_sh = four_wire_command_mode ? {sh[3:0], io_s2}
                                           : {sh[6:0], io_s2[0]};
   assign next_bitcnt = bitcnt + step;
   assign byte_done   = rise && (next_bitcnt == 3'd0);
   // opcode acceptance per mode and busy state
   always_comb begin
      case (next_sh)
         `OP_RDSR:      op_ok = 1'b1;
         `OP_WREN:      op_ok = !op_in_progress_flag;
         `OP_SEC_ERASE,
         `OP_SEC_PROG:  op_ok = !op_in_progress_flag
                               && !four_wire_command_mode
                               && write_latch_flag
                               && !secure_lock_flag;
         `OP_SEC_READ,
         `OP_SFDP,
         `OP_SET_WRAP:  op_ok = !op_in_progress_flag
                               && !four_wire_command_mode;
         `OP_QPI_ON:    op_ok = !op_in_progress_flag
                               && !four_wire_command_mode
                               && quad_allow_flag;
         `OP_SET_PARAM,
         `OP_WRAP_READ,
         `OP_QPI_OFF:   op_ok = !op_in_progress_flag
                               && four_wire_command_mode;
         default:       op_ok = 1'b0;
      endcase
   end
   // parameter table tail and read source selection
   assign pt_tail = `PT_TAIL;
   assign pt_idx  = addr[7:0] - `PT_BASE;
   always_comb begin
      rd_byte = `PT_RSVD;
      if (op == `OP_RDSR) begin
         rd_byte = 8'h00;
         rd_byte[`SR_WIP_BIT] = op_in_progress_flag;
         rd_byte[`SR_WEL_BIT] = write_latch_flag;
      end else if (op == `OP_SFDP) begin
         if (addr[7:0] == `PT_NOQ_ADDR)
            rd_byte = `PT_NOQ_VAL;
         else if (addr[7:0] >= `PT_BASE && pt_idx < `PT_LEN)
            rd_byte = pt_tail[79 - 8*pt_idx[3:0] -: 8];
      end else begin
         rd_byte = mem[addr[9:0]];
      end
   end
   // next read address: window wrap for 0Ch, full area otherwise
   assign wlen  = `WRAP_MIN << wrap_sel;
   assign wmask = {3'b000, wlen - 7'd1};
   assign next_rd_addr = (op == `OP_WRAP_READ)
      ? ((addr[9:0] & ~wmask) | ((addr[9:0] + 10'd1) & wmask))
      : addr[9:0] + 10'd1;
   // command sequencer; a high select abandons any frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st                    <= ST_OPC;
         {op, sh, prm}         <= 24'h000000;
         {bitcnt, acnt, armed} <= 6'h00;
         dcnt                  <= 4'h0;
         addr                  <= 24'h000000;
      end else if (cs_s2) begin
         st                    <= ST_OPC;
         {bitcnt, acnt, armed} <= 6'h00;
      end else begin
         if (rise) begin
            sh     <= next_sh;
            bitcnt <= next_bitcnt;
         end
         case (st)
            ST_OPC: if (byte_done) begin
               op <= next_sh;
               if (!op_ok)
                  st <= ST_SKIP;
               else if (next_sh == `OP_RDSR)
                  st <= ST_RDATA;
               else if (next_sh == `OP_WREN || next_sh == `OP_QPI_ON
                        || next_sh == `OP_QPI_OFF) begin
                  st    <= ST_TAIL;
                  armed <= 1'b1;
               end else if (next_sh == `OP_SET_PARAM
                            || next_sh == `OP_SET_WRAP)
                  st <= ST_WDATA;
               else
                  st <= ST_ADDR;
            end
            ST_ADDR: if (byte_done) begin
               addr <= {addr[15:0], next_sh};
               acnt <= acnt + 2'd1;
               if (acnt == `ADDR_LAST_IDX) begin
                  if (op == `OP_SEC_ERASE) begin
                     st    <= ST_TAIL;
                     armed <= 1'b1;
                  end else if (op == `OP_SEC_PROG)
                     st <= ST_WDATA;
                  else begin
                     st   <= ST_DUMMY;
                     dcnt <= (op == `OP_WRAP_READ)
                        ? {1'b0, dummy_sel, 1'b0} + 4'd2
                        : `SPI_DUMMY;
                  end
               end
            end
            ST_DUMMY: if (rise) begin
               dcnt <= dcnt - 4'd1;
               if (dcnt == 4'd1)
                  st <= ST_RDATA;
            end
            ST_WDATA: if (rise) begin
               armed <= byte_done;
               if (byte_done) begin
                  prm <= next_sh;
                  if (op == `OP_SEC_PROG)
                     addr[7:0] <= addr[7:0] + 8'd1;
               end
            end
            ST_TAIL: if (rise) begin
               armed <= 1'b0;
               st    <= ST_SKIP;
            end
            ST_RDATA: if (fall && ocnt == 3'd0 && op != `OP_RDSR)
               addr[9:0] <= next_rd_addr;
            default: ;
         endcase
      end
   end
   // data out, changed on falling link edges, MSB first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {osh, ocnt}                 <= 11'h000;
         {link.dev_out, link.dev_oe} <= 8'h00;
      end else if (cs_s2) begin
         ocnt        <= 3'd0;
         link.dev_oe <= 4'h0;
      end else if (fall && st == ST_RDATA) begin
         ocnt <= ocnt + step;
         if (four_wire_command_mode) begin
            link.dev_out <= (ocnt == 3'd0) ? rd_byte[7:4] : osh[7:4];
            osh          <= (ocnt == 3'd0) ? {rd_byte[3:0], 4'h0}
                                           : {osh[3:0], 4'h0};
            link.dev_oe  <= 4'hF;
         end else begin
            link.dev_out <= {2'b00, (ocnt == 3'd0) ? rd_byte[7]
                                                   : osh[7], 1'b0};
            osh          <= (ocnt == 3'd0) ? {rd_byte[6:0], 1'b0}
                                           : {osh[6:0], 1'b0};
            link.dev_oe  <= 4'h2;
         end
      end
   end
   // mode, latch and read settings; commands executed when select rises, latch dropped as a write cycle ends
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         four_wire_command_mode <= 1'b0;
         write_latch_flag       <= 1'b0;
         wrap_sel               <= 2'd0;
         dummy_sel              <= 2'd0;
      end else if (cs_up && armed) begin
         case (op)
            `OP_WREN:     write_latch_flag <= 1'b1;
            `OP_QPI_ON:   four_wire_command_mode <= 1'b1;
            `OP_QPI_OFF:  four_wire_command_mode <= 1'b0;
            `OP_SET_WRAP: wrap_sel <= prm[`W_WRAP_MSB:`W_WRAP_LSB];
            `OP_SET_PARAM: begin
               dummy_sel <= prm[`P_DUMMY_MSB:`P_DUMMY_LSB];
               wrap_sel  <= prm[`P_WRAP_MSB:`P_WRAP_LSB];
            end
            default: ;
         endcase
      end else if (op_in_progress_flag && busy_cnt == 16'd1) begin
         write_latch_flag <= 1'b0;
      end
   end
   // self-timed cycles; the erase wipes one byte per cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_in_progress_flag <= 1'b0;
         erasing             <= 1'b0;
         busy_cnt            <= 16'd0;
      end else if (cs_up && armed && op == `OP_SEC_ERASE) begin
         op_in_progress_flag <= 1'b1;
         erasing             <= 1'b1;
         busy_cnt            <= 16'(ERASE_CYCLES);
      end else if (cs_up && armed && op == `OP_SEC_PROG) begin
         op_in_progress_flag <= 1'b1;
         busy_cnt            <= 16'(PROG_CYCLES);
      end else if (op_in_progress_flag) begin
         busy_cnt <= busy_cnt - 16'd1;
         if (busy_cnt == 16'd1) begin
            op_in_progress_flag <= 1'b0;
            erasing             <= 1'b0;
         end
      end
   end
   // array: program only clears bits; erase writes back to FFh
   always_ff @(posedge hclk) begin
      if (erasing && busy_cnt <= 16'(`SEC_BYTES))
         mem[busy_cnt[9:0]] <= `ERASED_BYTE;
      else if (!cs_s2 && st == ST_WDATA && byte_done
               && op == `OP_SEC_PROG)
         mem[addr[9:0]] <= mem[addr[9:0]] & next_sh;
   end
endmodule // sec_flash_dev

/* File: hw/sec_flash_host.sv */
`timescale 1ns/1ps
`include "sec_flash_map.svh"
module sec_flash_host import sec_flash_pkg::*; (
   input  wire logic        hclk,      // system clock
   input  wire logic        hresetn,   // async reset, low active
   input  wire logic        hsel,      // slave select
   input  wire logic [31:0] haddr,     // byte address
   input  wire logic [1:0]  htrans,    // transfer type
   input  wire logic        hwrite,    // write when high
   input  wire logic [2:0]  hsize,     // word only
   input  wire logic        hready,    // bus ready
   input  wire logic [31:0] hwdata,    // write data
   output logic      [31:0] hrdata,    // read data
   output logic             hreadyout, // always ready
   output logic             hresp,     // always OKAY
   sec_flash_if.host        link       // serial link pins
);
   localparam logic [3:0] HALF_M1 =
      4'(`LINK_PERIOD_NS / (2 * `HCLK_PERIOD_NS) - 1);
   logic       wr_pend, ctrl_cs, ctrl_quad, busy, quad, sending;
   logic [7:0] wr_addr, sh, ish, rx;
   logic [3:0] io_s1, io_s2, hdiv, left;
   logic       tx_go;
   logic [7:0] next_ish;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign tx_go     = wr_pend && wr_addr == `REG_TX && !busy;
   assign next_ish  = quad ? {ish[3:0], io_s2} : {ish[6:0], io_s2[1]};

   // io synchroniser; read lanes only after two stages
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end else begin
         io_s1 <= link.io;
         io_s2 <= io_s1;
      end
   end

   // bus address phase; reads answered in the next cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0;
      end else begin
         wr_pend <= hsel && hready && htrans[1] && hwrite;
         wr_addr <= haddr[7:0];
         if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == `REG_CTRL)
               hrdata <= {30'h0, ctrl_quad, ctrl_cs};
            else if (haddr[7:0] == `REG_RX)
               hrdata <= {24'h0, rx};
            else if (haddr[7:0] == `REG_STAT)
               hrdata <= {31'h0, busy};
            else
               hrdata <= 32'h0;
         end
      end
   end

   // frame control; select only moves while no byte is in flight
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_cs   <= 1'b0;
         ctrl_quad <= 1'b0;
         link.cs_n <= 1'b1;
      end else if (wr_pend && wr_addr == `REG_CTRL && !busy) begin
         ctrl_cs   <= hwdata[`CTRL_CS_BIT];
         ctrl_quad <= hwdata[`CTRL_QUAD_BIT];
         link.cs_n <= !hwdata[`CTRL_CS_BIT];
      end
   end

   // byte engine: drive on falling edge, sample before the next fall
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy          <= 1'b0;
         quad          <= 1'b0;
         sending       <= 1'b0;
         sh            <= 8'h00;
         ish           <= 8'h00;
         rx            <= 8'h00;
         hdiv          <= 4'd0;
         left          <= 4'd0;
         link.sclk     <= 1'b0;
         link.host_out <= 4'h0;
         link.host_oe  <= 4'h0;
      end else if (tx_go) begin
         busy    <= 1'b1;
         quad    <= ctrl_quad;
         sending <= !hwdata[`TX_RECV_BIT];
         hdiv    <= 4'd0;
         left    <= ctrl_quad ? 4'd2 : 4'd8;
         link.host_oe  <= hwdata[`TX_RECV_BIT] ? 4'h0
                          : (ctrl_quad ? 4'hF : 4'h1);
         link.host_out <= ctrl_quad ? hwdata[7:4] : {3'b000, hwdata[7]};
         sh <= ctrl_quad ? {hwdata[3:0], 4'h0} : {hwdata[6:0], 1'b0};
      end else if (busy) begin
         hdiv <= (hdiv == HALF_M1) ? 4'd0 : hdiv + 4'd1;
         if (hdiv == HALF_M1) begin
            if (!link.sclk)
               link.sclk <= 1'b1;
            else begin
               link.sclk <= 1'b0;
               ish  <= next_ish;
               left <= left - 4'd1;
               if (left == 4'd1) begin
                  busy <= 1'b0;
                  rx   <= next_ish;
               end else if (sending) begin
                  link.host_out <= quad ? sh[7:4] : {3'b000, sh[7]};
                  sh <= quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
               end
            end
         end
      end
   end
endmodule // sec_flash_host

/* File: test/sec_flash_monitor.sv */
`timescale 1ns/1ps
module sec_flash_monitor (
   input wire logic       hclk,                   // system clock
   input wire logic       hresetn,                // reset, low active
   input wire logic       cs_n,                   // link select, low active
   input wire logic [3:0] dev_oe,                 // device lane enables
   input wire logic       secure_lock_flag,       // area locked
   input wire logic       quad_allow_flag,        // entry allowed
   input wire logic       four_wire_command_mode, // mode status
   input wire logic       write_latch_flag,       // latch status
   input wire logic       op_in_progress_flag     // busy status
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // a write cycle starts only after a clean, latched, unlocked frame
   a_latch_before_busy: assert property (
      $rose(op_in_progress_flag) |-> $past(write_latch_flag))
      else $error("write cycle began without latch");
   a_busy_after_frame: assert property (
      $rose(op_in_progress_flag) |-> cs_n && $past(cs_n, 2))
      else $error("write cycle began inside a frame");
   a_lock_blocks_write: assert property (
      $rose(op_in_progress_flag) |-> !$past(secure_lock_flag))
      else $error("write cycle began while locked");
   // self-timed cycle stands, then drops the latch
   a_busy_holds: assert property (
      $rose(op_in_progress_flag) |-> op_in_progress_flag [*7])
      else $error("busy flag dropped early");
   a_latch_clear_end: assert property (
      $fell(op_in_progress_flag) |-> ##[0:1] !write_latch_flag)
      else $error("latch kept after write cycle");
   // mode moves only between frames and carries the latch across
   a_entry_allowed: assert property (
      $rose(four_wire_command_mode) |-> $past(quad_allow_flag) && cs_n)
      else $error("four-wire entry without permission");
   a_switch_keeps_latch: assert property (
      $changed(four_wire_command_mode) |-> $stable(write_latch_flag) && cs_n)
      else $error("mode switch disturbed latch or frame");
   // one output lane in single-wire mode; all lanes freed after a frame
   a_spi_one_lane: assert property (
      !four_wire_command_mode && !$past(four_wire_command_mode)
      |-> (dev_oe & 4'hD) == 4'h0)
      else $error("extra lanes driven in single-wire mode");
   a_release_lanes: assert property (
      $rose(cs_n) |-> ##[1:6] dev_oe == 4'h0)
      else $error("lanes still driven after frame end");
   c_write_done: cover property ($fell(op_in_progress_flag));
   c_quad_on: cover property ($rose(four_wire_command_mode));
   c_quad_off: cover property ($fell(four_wire_command_mode));
   c_quad_drive: cover property (dev_oe == 4'hF);
endmodule // sec_flash_monitor

/* File: test/security_sector_qpi_cmds_bench.sv */
`timescale 1ns/1ps
module security_sector_qpi_cmds_bench;
   logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, q4 = 1'b0;
   logic        lock = 1'b0, qallow = 1'b0, hreadyout, mode, wl, busy;
   logic        hresp;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [7:0]  mem [1024];
   logic [7:0]  rx_q [$];
   integer      errors = 0, checks_done = 0, seed = 80, i, k;
   localparam logic [7:0] TBL [13] = '{8'h00, 8'hFF, 8'hFF, 8'h08, 8'hEB,
      8'h0C, 8'h20, 8'h0F, 8'h52, 8'h10, 8'hD8, 8'h00, 8'h00};
   sec_flash_if lnk ();
   sec_flash_host i_sec_flash_host (.hclk(hclk), .hresetn(hresetn),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link(lnk));
   sec_flash_dev #(.ERASE_CYCLES(1100), .PROG_CYCLES(8)) i_sec_flash_dev (
      .hclk(hclk), .hresetn(hresetn), .link(lnk), .secure_lock_flag(lock),
      .quad_allow_flag(qallow), .four_wire_command_mode(mode),
      .write_latch_flag(wl), .op_in_progress_flag(busy));
   sec_flash_monitor i_sec_flash_monitor (.hclk(hclk), .hresetn(hresetn),
      .cs_n(lnk.cs_n), .dev_oe(lnk.dev_oe), .secure_lock_flag(lock),
      .quad_allow_flag(qallow), .four_wire_command_mode(mode),
      .write_latch_flag(wl), .op_in_progress_flag(busy));
   // system clock, 50 ns period
   always #25 hclk = ~hclk;
   // compare and count; case inequality so unknowns never match
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // single AHB transfer, entered just after a rising edge
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      chk("bus response", 8'h00, {7'h0, hresp});
   endtask
   // one link byte: TX write, poll until idle, fetch RX
   task automatic xb(input logic [7:0] b, input logic r,
                     output logic [7:0] v);
      logic [31:0] q;
      bus(8'h04, 1'b1, {23'h0, r, b}, q);
      do bus(8'h0C, 1'b0, 32'h0, q); while (q[0] !== 1'b0);
      bus(8'h08, 1'b0, 32'h0, q);
      v = q[7:0];
   endtask
   // whole frame: select, send t, collect n bytes, deselect, idle gap
   task automatic frame(input logic [7:0] t [$], input int n);
      logic [31:0] q;
      logic [7:0]  v;
      bus(8'h00, 1'b1, {30'h0, q4, 1'b1}, q);
      foreach (t[j]) xb(t[j], 1'b0, v);
      rx_q = {};
      repeat (n) begin
         xb(8'h00, 1'b1, v);
         rx_q.push_back(v);
      end
      bus(8'h00, 1'b1, {30'h0, q4, 1'b0}, q);
      repeat (6) @(posedge hclk);
   endtask
   // status low bits: busy and latch
   task automatic stat_is(input string n, input logic [7:0] e);
      frame('{8'h05}, 1);
      chk(n, e, {6'h0, rx_q[0][1:0]});
   endtask
   // the poll is bounded only by the watchdog
   task automatic wait_idle;
      do frame('{8'h05}, 1); while (rx_q[0][0] !== 1'b0);
   endtask
   // expected address inside an aligned window of len bytes
   function automatic logic [9:0] wrap_at(logic [9:0] a, int j, int len);
      return 10'((a & ~(len - 1)) | ((a + j) & (len - 1)));
   endfunction
   // wrapped four-wire read from a random start near the top
   task automatic wrap_rd(input int dum, input int len);
      logic [9:0] a;
      a = 10'h3F8 | 10'($random(seed) & 7);
      frame('{8'h0C, 8'h00, {6'h0, a[9:8]}, a[7:0]}, dum / 2 + 10);
      for (int j = 0; j < 10; j++)
         chk("wrap", mem[wrap_at(a, j, len)], rx_q[j + dum / 2]);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // hang guard, several times the expected run
   initial begin
      #2_500_000;
      errors++;
      end_of_test;
   end
   // reset, then the tests in order
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("reset flags", 8'h00, {5'h0, mode, wl, busy});
      frame('{8'h5A, 8'h00, 8'h00, 8'h97}, 14);
      for (i = 0; i < 13; i++)
         chk("table", TBL[i], rx_q[i + 1]);
      $display("test table done");
      frame('{8'h44, 8'h00, 8'h00, 8'h00}, 0);
      stat_is("erase unlatched", 8'h00);
      lock <= 1'b1;
      frame('{8'h06}, 0);
      frame('{8'h44, 8'h00, 8'h00, 8'h00}, 0);
      frame('{8'h42, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
      stat_is("locked", 8'h02);
      lock <= 1'b0;
      frame('{8'h44, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
      stat_is("stray byte", 8'h02);
      frame('{8'h44, 8'h00, 8'h03, 8'hFF}, 0);
      stat_is("erase busy", 8'h03);
      frame('{8'h48, 8'h00, 8'h00, 8'h00}, 2);
      chk("read while busy", 8'hFF, rx_q[1]);
      wait_idle;
      stat_is("erase done", 8'h00);
      foreach (mem[j]) mem[j] = 8'hFF;
      $display("test erase done");
      frame('{8'h06}, 0);
      for (i = 0; i < 4; i++)
         mem[1020 + i] = 8'($random(seed));
      frame('{8'h42, 8'h00, 8'h03, 8'hFC, mem[1020], mem[1021],
              mem[1022], mem[1023]}, 0);
      wait_idle;
      stat_is("program done", 8'h00);
      frame('{8'h42, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
      frame('{8'h48, 8'h00, 8'h03, 8'hFE}, 5);
      for (i = 0; i < 4; i++)
         chk("area read", mem[10'(1022 + i)], rx_q[i + 1]);
      $display("test program done");
      frame('{8'hC0, 8'h31}, 0);
      frame('{8'h38}, 0);
      chk("entry refused", 8'h00, {7'h0, mode});
      qallow <= 1'b1;
      frame('{8'h06}, 0);
      frame('{8'h38}, 0);
      q4 = 1'b1;
      chk("entry", 8'h03, {6'h0, mode, wl});
      wrap_rd(2, 8);
      for (k = 0; k < 4; k++) begin
         frame('{8'hC0, {2'b00, 2'(k), 2'b00, 2'(3 - k)}}, 0);
         wrap_rd(2 * k + 2, 8 << (3 - k));
      end
      frame('{8'hFF}, 0);
      q4 = 1'b0;
      chk("exit", 8'h01, {6'h0, mode, wl});
      frame('{8'h0C, 8'h00, 8'h03, 8'hF8}, 2);
      stat_is("bad opcode", 8'h02);
      frame('{8'h77, 8'h30}, 0);
      frame('{8'h38}, 0);
      q4 = 1'b1;
      wrap_rd(8, 64);
      frame('{8'hFF}, 0);
      q4 = 1'b0;
      $display("test modes done");
      end_of_test;
   end
endmodule // security_sector_qpi_cmds_bench
